//--- verilog/dsrl_pkg.sv
// Constants shared by the drive status and reference link block.
// Assumes a single 20 MHz device clock and an APB register bus.
package dsrl_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and timing
   localparam int unsigned CLK_HZ           = 20000000;
   localparam int unsigned MS_PER_S         = 1000;
   localparam int unsigned MS_CYCLES        = CLK_HZ / MS_PER_S;

   ////////////////////////////////////////////////////////////////////////////////
   // APB register byte offsets
   localparam logic [7:0]  OFS_CONFIG       = 8'h00;
   localparam logic [7:0]  OFS_REF_LIMITS   = 8'h04;
   localparam logic [7:0]  OFS_FREQ_LIMITS  = 8'h08;
   localparam logic [7:0]  OFS_CURRENT      = 8'h0c;
   localparam logic [7:0]  OFS_STATUS       = 8'h10;
   localparam logic [7:0]  OFS_REF_RAW      = 8'h14;
   localparam logic [7:0]  OFS_REF_SCALED   = 8'h18;
   localparam logic [7:0]  OFS_FREQ_CODE    = 8'h1c;

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration register fields
   localparam int unsigned CFG_ADDR_LSB     = 0;
   localparam int unsigned CFG_BAUD_LSB     = 8;
   localparam int unsigned CFG_PROTO_LSB    = 12;
   localparam logic [6:0]  NODE_ADDR_MAX    = 7'h7e;
   localparam logic [6:0]  NODE_ADDR_RESET  = 7'h01;
   localparam logic [2:0]  BAUD_CODE_MAX    = 3'h5;
   localparam logic [2:0]  BAUD_CODE_RESET  = 3'h5;
   localparam logic [1:0]  PROTO_RESET      = 2'h0;

   // Bit rates selected by the baud code
   localparam int unsigned BAUD_300         = 300;
   localparam int unsigned BAUD_600         = 600;
   localparam int unsigned BAUD_1200        = 1200;
   localparam int unsigned BAUD_2400        = 2400;
   localparam int unsigned BAUD_4800        = 4800;
   localparam int unsigned BAUD_9600        = 9600;

   ////////////////////////////////////////////////////////////////////////////////
   // Status word bit positions and status register fields
   localparam int unsigned ST_IN_RANGE      = 10;
   localparam int unsigned ST_RUNNING       = 11;
   localparam int unsigned ST_NO_FUNC       = 12;
   localparam int unsigned ST_VOLT_WARN     = 13;
   localparam int unsigned ST_CUR_LIMIT     = 14;
   localparam int unsigned ST_THERMAL       = 15;
   localparam int unsigned ST_TRIP_BIT      = 16;

   ////////////////////////////////////////////////////////////////////////////////
   // Reference and frequency scaling
   localparam int unsigned SCALE_SHIFT      = 14;
   localparam logic signed [17:0] CODE_MAX  = 18'sh07fff;
   localparam logic signed [17:0] CODE_MIN  = -18'sh07fff;
   localparam logic [15:0] REF_MOST_NEG     = 16'h8000;
   localparam logic [15:0] REF_MAG_MAX      = 16'h7fff;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial parameter identifiers
   localparam logic [1:0]  PAR_ADDRESS      = 2'h0;
   localparam logic [1:0]  PAR_BAUD         = 2'h1;
   localparam logic [1:0]  PAR_PROTOCOL     = 2'h2;

   // Reset values of the limit registers
   localparam logic [31:0] REF_LIMITS_RESET = 32'h4000_0000;
   localparam logic [31:0] FREQ_LIM_RESET   = 32'h4000_0000;
   localparam logic [31:0] CURRENT_RESET    = 32'h0064_ffff;

   // Pin flags that pass the synchroniser
   localparam int unsigned COND_W           = 7;

endpackage : dsrl_pkg

//--- verilog/dsrl_cond_if.sv
// Carries the asynchronous condition pins and their synchronised copies.
// Assumes both modports sit on the single device clock.
interface dsrl_cond_if;
   import dsrl_pkg::*;

   logic [COND_W-1:0] raw;
   logic [COND_W-1:0] synced;

   // Producer of the synchronised flags
   modport sync_side (
      input  raw,
      output synced
   );

   // Consumer of the synchronised flags
   modport user_side (
      output raw,
      input  synced
   );

endinterface : dsrl_cond_if

//--- verilog/dsrl_sync.sv
// Two-flop synchroniser for a group of asynchronous condition pins.
// Assumes the pins are slow levels with no mutual timing relation.
module dsrl_sync (
   // Clock and reset
   input  wire logic          MCLK,
   input  wire logic          RST_N,
   // Condition flags
   dsrl_cond_if.sync_side     cond
);
   import dsrl_pkg::*;

   logic [COND_W-1:0] meta_q;
   logic [COND_W-1:0] sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= cond.raw;
         sync_q <= meta_q;
      end
   end

   assign cond.synced = sync_q;

endmodule : dsrl_sync

//--- verilog/dsrl_link.sv
// Status word upper half, serial speed reference decode, output frequency
// encoding and link settings of the drive's serial slave.
// Assumes a link framer on MCLK delivers pulses and words, and that the
// local operator panel reaches the settings over APB.
//
// Behaviour
// (RULE_01) Status bit 10 is low when the output frequency sits at a limit and high inside them.
// (RULE_02) Status bit 11 is high with a start signal or any frequency above zero.
// (RULE_03) Status bit 12 has no function and the master must ignore it.
// (RULE_04) Status bit 13 is high while the DC link voltage is too low or too high.
// (RULE_05) Status bit 14 is high above the current limit, and a trip follows after the delay.
// (RULE_06) Status bit 15 is high on a motor, converter or thermistor over-temperature.
// (RULE_07) The reference is a signed 16-bit word over plus or minus 32767.
// (RULE_08) Reference 0 maps to the minimum and 16384 to the maximum, linearly.
// (RULE_09) A negative reference means the opposite direction of rotation.
// (RULE_10) Output frequency is sent signed, 0 at the low limit and 16384 at the high limit.
// (RULE_11) The protocol setting has one choice, code 0, also the default.
// (RULE_12) The node address lies in 0 to 126 and resets to 1, unique per network.
// (RULE_13) Node address writes from the link are refused; only the panel may change it.
// (RULE_14) Baud codes 0 to 5 mean 300 to 9600 bit/s, with 5 as the default.
// (RULE_15) The bit rate must match the master and link writes to it are refused.
// (RULE_16) The status word is sent to the master as a link slave.
// (RULE_17) Live condition flags are sampled into the status word for each reply.
//
// Added by the designer: the register addresses and register access over APB.
module dsrl_link #(
   parameter int unsigned MS_TICK = dsrl_pkg::MS_CYCLES
) (
   // Clock and reset
   input  wire logic          MCLK,
   input  wire logic          RST_N,
   // APB slave
   input  wire logic          PSEL,
   input  wire logic          PENABLE,
   input  wire logic          PWRITE,
   input  wire logic [7:0]    PADDR,
   input  wire logic [31:0]   PWDATA,
   output logic      [31:0]   PRDATA,
   output logic               PREADY,
   output logic               PSLVERR,
   // Condition pins, asynchronous
   input  wire logic          START_IN,
   input  wire logic          DC_LOW_IN,
   input  wire logic          DC_HIGH_IN,
   input  wire logic          MOTOR_HOT_IN,
   input  wire logic          CONV_HOT_IN,
   input  wire logic          THERM_HOT_IN,
   input  wire logic          TRIP_RESET_IN,
   // Measurements from drive logic
   input  wire logic [15:0]   OUT_FREQ,
   input  wire logic [15:0]   OUT_CURRENT,
   // Link framer side
   input  wire logic          REF_VALID,
   input  wire logic [15:0]   REF_WORD,
   input  wire logic          REPLY_REQ,
   input  wire logic          LINK_PAR_WR,
   input  wire logic [1:0]    LINK_PAR_ID,
   output logic               REPLY_VALID,
   output logic      [15:0]   STATUS_HIGH,
   output logic      [15:0]   FREQ_CODE,
   output logic               LINK_PAR_REJECT,
   // Drive side
   output logic      [15:0]   REF_SPEED,
   output logic               REF_REVERSE,
   output logic               TRIP,
   output logic      [6:0]    NODE_ADDR,
   output logic      [16:0]   BIT_CYCLES
);
   import dsrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Condition synchronisers
   dsrl_cond_if cond ();

   assign cond.raw = {TRIP_RESET_IN, THERM_HOT_IN, CONV_HOT_IN, MOTOR_HOT_IN,
                      DC_HIGH_IN, DC_LOW_IN, START_IN};

   dsrl_sync u_sync (
      .MCLK  (MCLK),
      .RST_N (RST_N),
      .cond  (cond.sync_side)
   );

   logic start_s;
   logic dc_low_s;
   logic dc_high_s;
   logic hot_any_s;
   logic trip_rst_s;

   assign start_s    = cond.synced[0];
   assign dc_low_s   = cond.synced[1];
   assign dc_high_s  = cond.synced[2];
   assign hot_any_s  = |cond.synced[5:3];
   assign trip_rst_s = cond.synced[6];

   ////////////////////////////////////////////////////////////////////////////////
   // Settings registers
   logic [6:0]  addr_q;
   logic [2:0]  baud_q;
   logic [1:0]  proto_q;
   logic [31:0] ref_lim_q;
   logic [31:0] freq_lim_q;
   logic [31:0] cur_q;
   logic        wr_en;

   assign wr_en = PSEL & PENABLE & PWRITE;

   // Panel writes to node address, baud code and protocol
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         addr_q  <= NODE_ADDR_RESET;
         baud_q  <= BAUD_CODE_RESET;
         proto_q <= PROTO_RESET;
      end else if (wr_en && PADDR == OFS_CONFIG) begin
         // (RULE_12) keep address in range
         if (PWDATA[CFG_ADDR_LSB +: 7] <= NODE_ADDR_MAX) begin
            addr_q <= PWDATA[CFG_ADDR_LSB +: 7];
         end
         // (RULE_14) only codes 0 to 5
         if (PWDATA[CFG_BAUD_LSB +: 3] <= BAUD_CODE_MAX) begin
            baud_q <= PWDATA[CFG_BAUD_LSB +: 3];
         end
         // (RULE_11) single protocol choice
         proto_q <= PROTO_RESET;
      end
   end

   // Limit registers
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         ref_lim_q  <= REF_LIMITS_RESET;
         freq_lim_q <= FREQ_LIM_RESET;
         cur_q      <= CURRENT_RESET;
      end else if (wr_en) begin
         if (PADDR == OFS_REF_LIMITS) begin
            ref_lim_q <= PWDATA;
         end
         if (PADDR == OFS_FREQ_LIMITS) begin
            freq_lim_q <= PWDATA;
         end
         if (PADDR == OFS_CURRENT) begin
            cur_q <= PWDATA;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Link parameter writes
   // (RULE_13) (RULE_15) refuse link writes
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         LINK_PAR_REJECT <= 1'b0;
      end else begin
         LINK_PAR_REJECT <= LINK_PAR_WR && (LINK_PAR_ID == PAR_ADDRESS ||
                            LINK_PAR_ID == PAR_BAUD || LINK_PAR_ID == PAR_PROTOCOL);
      end
   end

   // (RULE_14) bit period per baud code
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         BIT_CYCLES <= 17'(CLK_HZ / BAUD_9600);
      end else begin
         case (baud_q)
            3'h0:    BIT_CYCLES <= 17'(CLK_HZ / BAUD_300);
            3'h1:    BIT_CYCLES <= 17'(CLK_HZ / BAUD_600);
            3'h2:    BIT_CYCLES <= 17'(CLK_HZ / BAUD_1200);
            3'h3:    BIT_CYCLES <= 17'(CLK_HZ / BAUD_2400);
            3'h4:    BIT_CYCLES <= 17'(CLK_HZ / BAUD_4800);
            default: BIT_CYCLES <= 17'(CLK_HZ / BAUD_9600);
         endcase
      end
   end

   assign NODE_ADDR = addr_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Live status flags
   logic [15:0] f_low;
   logic [15:0] f_high;
   logic [5:0]  status_live;
   logic        over_cur;

   assign f_low    = freq_lim_q[15:0];
   assign f_high   = freq_lim_q[31:16];
   assign over_cur = OUT_CURRENT > cur_q[15:0];

   always_comb begin
      // (RULE_01) inside the frequency limits
      status_live[0] = (OUT_FREQ > f_low) && (OUT_FREQ < f_high);
      // (RULE_02) start or nonzero frequency
      status_live[1] = start_s || (OUT_FREQ != 16'h0000);
      // (RULE_03) no function, fixed low
      status_live[2] = 1'b0;
      // (RULE_04) DC link voltage warning
      status_live[3] = dc_low_s || dc_high_s;
      // (RULE_05) current limit flag
      status_live[4] = over_cur;
      // (RULE_06) any over-temperature
      status_live[5] = hot_any_s;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Overcurrent trip timer
   logic [14:0] tick_q;
   logic [15:0] ms_q;

   // Counts whole milliseconds spent over the limit
   always_ff @(posedge MCLK) begin
      if (!RST_N || !over_cur) begin
         tick_q <= '0;
         ms_q   <= '0;
      end else if (tick_q == 15'(MS_TICK - 1)) begin
         tick_q <= '0;
         if (ms_q != 16'hffff) begin
            ms_q <= ms_q + 16'h0001;
         end
      end else begin
         tick_q <= tick_q + 15'h0001;
      end
   end

   // (RULE_05) trip once the delay has passed; the set wins over clear
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         TRIP <= 1'b0;
      end else if (over_cur && ms_q >= cur_q[31:16]) begin
         TRIP <= 1'b1;
      end else if (trip_rst_s || (wr_en && PADDR == OFS_STATUS && PWDATA[ST_TRIP_BIT])) begin
         TRIP <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reference decode
   logic [15:0]        ref_raw_q;
   logic [15:0]        ref_mag;
   logic [15:0]        r_min;
   logic [15:0]        r_max;
   logic signed [17:0] r_span;
   logic signed [33:0] r_prod;
   logic signed [33:0] r_sum;

   // (RULE_07) clamp the most negative word to -32767
   assign ref_mag = ref_raw_q[15] ? ((ref_raw_q == REF_MOST_NEG) ? REF_MAG_MAX
                                     : 16'(-ref_raw_q)) : ref_raw_q;
   assign r_min   = ref_lim_q[15:0];
   assign r_max   = ref_lim_q[31:16];
   assign r_span  = $signed({2'b00, r_max}) - $signed({2'b00, r_min});
   assign r_prod  = 34'(r_span) * 34'($signed({2'b00, ref_mag}));
   assign r_sum   = $signed({18'h00000, r_min}) + (r_prod >>> SCALE_SHIFT);

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         ref_raw_q <= '0;
      end else if (REF_VALID) begin
         ref_raw_q <= REF_WORD;
      end
   end

   // (RULE_08) linear map with saturation to the output width
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         REF_SPEED   <= '0;
         REF_REVERSE <= 1'b0;
      end else begin
         if (r_sum < 0) begin
            REF_SPEED <= '0;
         end else if (r_sum > 34'sh0ffff) begin
            REF_SPEED <= 16'hffff;
         end else begin
            REF_SPEED <= r_sum[15:0];
         end
         // (RULE_09) negative reference reverses
         REF_REVERSE <= ref_raw_q[15];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output frequency encoding
   logic signed [17:0] f_span;
   logic signed [17:0] f_off;
   logic signed [35:0] f_quot;
   logic signed [17:0] f_code;

   assign f_span = $signed({2'b00, f_high}) - $signed({2'b00, f_low});
   assign f_off  = $signed({2'b00, OUT_FREQ}) - $signed({2'b00, f_low});

   // (RULE_10) scale so the low limit is 0 and the high limit 16384
   always_comb begin
      f_quot = '0;
      if (f_span > 0) begin
         f_quot = (36'(f_off) <<< SCALE_SHIFT) / 36'(f_span);
      end
      if (f_quot > 36'(CODE_MAX)) begin
         f_code = CODE_MAX;
      end else if (f_quot < 36'(CODE_MIN)) begin
         f_code = CODE_MIN;
      end else begin
         f_code = f_quot[17:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Reply capture
   // (RULE_16) (RULE_17) snapshot live state per reply
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         STATUS_HIGH <= '0;
         FREQ_CODE   <= '0;
         REPLY_VALID <= 1'b0;
      end else begin
         REPLY_VALID <= REPLY_REQ;
         if (REPLY_REQ) begin
            STATUS_HIGH <= {status_live, 10'h000};
            FREQ_CODE   <= f_code[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB read path, zero wait states
   assign PREADY = 1'b1;

   always_comb begin
      PRDATA  = '0;
      PSLVERR = 1'b0;
      if (PSEL && PENABLE) begin
         case (PADDR)
            OFS_CONFIG: begin
               PRDATA[CFG_ADDR_LSB +: 7]  = addr_q;
               PRDATA[CFG_BAUD_LSB +: 3]  = baud_q;
               PRDATA[CFG_PROTO_LSB +: 2] = proto_q;
            end
            OFS_REF_LIMITS:  PRDATA = ref_lim_q;
            OFS_FREQ_LIMITS: PRDATA = freq_lim_q;
            OFS_CURRENT:     PRDATA = cur_q;
            OFS_STATUS: begin
               PRDATA[ST_THERMAL:ST_IN_RANGE] = status_live;
               PRDATA[ST_TRIP_BIT]            = TRIP;
            end
            OFS_REF_RAW:     PRDATA = {16'h0000, ref_raw_q};
            OFS_REF_SCALED:  PRDATA = {15'h0000, REF_REVERSE, REF_SPEED};
            OFS_FREQ_CODE:   PRDATA = {16'h0000, FREQ_CODE};
            default:         PSLVERR = 1'b1;
         endcase
      end
   end

endmodule : dsrl_link

//--- test/dsrl_link_props.sv
// Concurrent checks on the ports of the link block.
// Assumes one clock MCLK and a synchronous active-low RST_N.
module dsrl_link_props (
   // Clock and reset
   input wire logic        MCLK,
   input wire logic        RST_N,
   // APB
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   // Link framer side
   input wire logic        REF_VALID,
   input wire logic [15:0] REF_WORD,
   input wire logic        REPLY_REQ,
   input wire logic        LINK_PAR_WR,
   input wire logic [1:0]  LINK_PAR_ID,
   input wire logic        REPLY_VALID,
   input wire logic [15:0] STATUS_HIGH,
   input wire logic        LINK_PAR_REJECT,
   // Drive side
   input wire logic [15:0] OUT_FREQ,
   input wire logic        REF_REVERSE,
   input wire logic [6:0]  NODE_ADDR,
   input wire logic [16:0] BIT_CYCLES
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   // Register write in its access phase
   wire apb_wr = PSEL && PENABLE && PWRITE;
   ////////////////////////////////////////
   // Reference and reply sequences
   sequence s_ref;
      REF_VALID ##1 !REF_VALID;
   endsequence
   property p_ref_dir;
      s_ref |=> REF_REVERSE == $past(REF_WORD[15], 2);
   endproperty
   a_ref_dir: assert property (p_ref_dir) else $error("reverse flag wrong");
   property p_reply;
      REPLY_REQ |=> REPLY_VALID;
   endproperty
   a_reply: assert property (p_reply) else $error("no reply pulse");
   property p_reply_only;
      !REPLY_REQ |=> !REPLY_VALID && $stable(STATUS_HIGH);
   endproperty
   a_reply_only: assert property (p_reply_only) else $error("reply not requested");
   property p_running;
      REPLY_REQ && OUT_FREQ != 16'h0000 |=> STATUS_HIGH[11];
   endproperty
   a_running: assert property (p_running) else $error("running bit low");
   property p_bit12;
      STATUS_HIGH[12] == 1'b0 && STATUS_HIGH[9:0] == 10'h000;
   endproperty
   a_bit12: assert property (p_bit12) else $error("unused status bit set");
   ////////////////////////////////////////
   // Link settings
   property p_par_reject;
      LINK_PAR_WR && LINK_PAR_ID != 2'h3 |=> LINK_PAR_REJECT;
   endproperty
   a_par_reject: assert property (p_par_reject) else $error("link write accepted");
   property p_par_quiet;
      !LINK_PAR_WR |=> !LINK_PAR_REJECT;
   endproperty
   a_par_quiet: assert property (p_par_quiet) else $error("spurious reject");
   property p_par_keep;
      LINK_PAR_WR && !apb_wr && !$past(apb_wr) |=> $stable(NODE_ADDR) && $stable(BIT_CYCLES);
   endproperty
   a_par_keep: assert property (p_par_keep) else $error("setting changed");
   property p_addr_range;
      NODE_ADDR <= 7'h7e;
   endproperty
   a_addr_range: assert property (p_addr_range) else $error("address out of range");
   property p_baud;
      BIT_CYCLES inside {17'h1046a, 17'h08235, 17'h0411a, 17'h0208d, 17'h01046, 17'h00823};
   endproperty
   a_baud: assert property (p_baud) else $error("bit time not a code");
endmodule : dsrl_link_props

bind dsrl_link dsrl_link_props u_props (
   .MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .REF_VALID(REF_VALID), .REF_WORD(REF_WORD), .REPLY_REQ(REPLY_REQ),
   .LINK_PAR_WR(LINK_PAR_WR), .LINK_PAR_ID(LINK_PAR_ID), .REPLY_VALID(REPLY_VALID),
   .STATUS_HIGH(STATUS_HIGH), .LINK_PAR_REJECT(LINK_PAR_REJECT), .OUT_FREQ(OUT_FREQ),
   .REF_REVERSE(REF_REVERSE), .NODE_ADDR(NODE_ADDR), .BIT_CYCLES(BIT_CYCLES)
);

//--- test/dsrl_link_master.sv
// Model of the serial bus master behind the link framer.
// Assumes requests are issued one at a time by the bench.
module dsrl_link_master (
   // Clock
   input wire logic        MCLK,
   // Requests
   output logic            REF_VALID,
   output logic [15:0]     REF_WORD,
   output logic            REPLY_REQ,
   output logic            LINK_PAR_WR,
   output logic [1:0]      LINK_PAR_ID,
   // Answers
   input wire logic        REPLY_VALID,
   input wire logic [15:0] STATUS_HIGH,
   input wire logic [15:0] FREQ_CODE
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle values at time zero
   initial begin
      {REF_VALID, REPLY_REQ, LINK_PAR_WR, LINK_PAR_ID, REF_WORD} = 21'h05a5a;
   end
   task send_ref(input logic [15:0] w);
      @(posedge MCLK);
      REF_VALID <= 1'b1;
      REF_WORD <= w;
      @(posedge MCLK);
      REF_VALID <= 1'b0;
      REF_WORD <= ~w;
   endtask : send_ref
   // master tries settings over the link
   task send_par(input logic [1:0] id);
      @(posedge MCLK);
      LINK_PAR_WR <= 1'b1;
      LINK_PAR_ID <= id;
      @(posedge MCLK);
      LINK_PAR_WR <= 1'b0;
      LINK_PAR_ID <= ~id;
   endtask : send_par
   task get_reply(output logic ok, output logic [15:0] st, output logic [15:0] fc);
      int i;
      ok = 1'b0;
      @(posedge MCLK);
      REPLY_REQ <= 1'b1;
      @(posedge MCLK);
      REPLY_REQ <= 1'b0;
      for (i = 0; i < 8 && !ok; i++) begin
         @(posedge MCLK);
         if (REPLY_VALID === 1'b1) begin
            ok = 1'b1;
            st = STATUS_HIGH & 16'hefff;
            fc = FREQ_CODE;
         end
      end
   endtask : get_reply
endmodule : dsrl_link_master

//--- test/tb_top.sv
// Self-checking bench for the link block.
// Assumes a 20 MHz clock and MS_TICK shortened to 10 cycles.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import dsrl_pkg::*;
   logic        MCLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, trip_rst;
   logic        REF_VALID, REPLY_REQ, LINK_PAR_WR, REPLY_VALID, PAR_REJ, REF_REVERSE, TRIP;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, PRDATA;
   logic [5:0]  pins;
   logic [1:0]  LINK_PAR_ID;
   logic [6:0]  NODE_ADDR;
   logic [16:0] BIT_CYCLES;
   logic [15:0] OUT_FREQ, OUT_CURRENT, REF_WORD, STATUS_HIGH, FREQ_CODE, REF_SPEED, st, fc;
   int          err_total, checks, i, j;
   logic [15:0] refs[6] = '{16'h2000, 16'he000, 16'h4000, 16'h7fff, 16'h8000, 16'h0000};
   logic [5:0]  spin[8] = '{6'h00, 6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
   logic [15:0] sfrq[8] = '{16'h0, 16'h19, 16'h0, 16'h32, 16'h19, 16'h0, 16'h0, 16'h0};
   logic [15:0] sexp[8] = '{16'h0, 16'h0c00, 16'h0800, 16'h2800, 16'h2c00, 16'h8000,
                            16'h8000, 16'h8000};
   dsrl_link #(.MS_TICK(10)) u_dut (
      .MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .START_IN(pins[0]), .DC_LOW_IN(pins[1]), .DC_HIGH_IN(pins[2]), .MOTOR_HOT_IN(pins[3]),
      .CONV_HOT_IN(pins[4]), .THERM_HOT_IN(pins[5]), .TRIP_RESET_IN(trip_rst),
      .OUT_FREQ(OUT_FREQ), .OUT_CURRENT(OUT_CURRENT), .REF_VALID(REF_VALID),
      .REF_WORD(REF_WORD), .REPLY_REQ(REPLY_REQ), .LINK_PAR_WR(LINK_PAR_WR),
      .LINK_PAR_ID(LINK_PAR_ID), .REPLY_VALID(REPLY_VALID), .STATUS_HIGH(STATUS_HIGH),
      .FREQ_CODE(FREQ_CODE), .LINK_PAR_REJECT(PAR_REJ), .REF_SPEED(REF_SPEED),
      .REF_REVERSE(REF_REVERSE), .TRIP(TRIP), .NODE_ADDR(NODE_ADDR), .BIT_CYCLES(BIT_CYCLES));
   dsrl_link_master u_mst (
      .MCLK(MCLK), .REF_VALID(REF_VALID), .REF_WORD(REF_WORD), .REPLY_REQ(REPLY_REQ),
      .LINK_PAR_WR(LINK_PAR_WR), .LINK_PAR_ID(LINK_PAR_ID), .REPLY_VALID(REPLY_VALID),
      .STATUS_HIGH(STATUS_HIGH), .FREQ_CODE(FREQ_CODE));
   // Clock generator, 50 ns period
   always #25 MCLK = ~MCLK;
   ////////////////////////////////////////
   // Verdict, compare and bus tasks
   task print_verdict();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [32:0] q);
      int n;
      @(posedge MCLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge MCLK);
         if (PREADY === 1'b1) break;
      end
      if (n == 16) begin
         err_total++;
         print_verdict();
      end
      q = {PSLVERR, PRDATA};
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [32:0] q;
      apb(1'b1, a, d, q);
   endtask : wr
   task rd_chk(input logic [7:0] a, input logic [32:0] exp);
      logic [32:0] q;
      apb(1'b0, a, 32'h0, q);
      chk(q[31:0], exp[31:0]);
      chk(q[32], exp[32]);
   endtask : rd_chk
   task reply();
      logic ok;
      u_mst.get_reply(ok, st, fc);
      if (ok !== 1'b1) begin
         err_total++;
         print_verdict();
      end
   endtask : reply
   function automatic logic [15:0] exp_speed(input logic [15:0] mn, mx, r);
      longint m, s;
      m = r[15] ? -longint'($signed(r)) : longint'(r);
      if (m > 32767) m = 32767;
      s = longint'(mn) + (((longint'(mx) - longint'(mn)) * m) >>> 14);
      if (s < 0) s = 0;
      if (s > 65535) s = 65535;
      return s[15:0];
   endfunction : exp_speed
   ////////////////////////////////////////
   // Main sequence
   initial begin
      {MCLK, PSEL, PENABLE, PWRITE, trip_rst, RST_N} = 6'h00;
      {PADDR, PWDATA, pins, OUT_FREQ, OUT_CURRENT} = 78'h0;
      repeat (5) @(posedge MCLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge MCLK);
      chk(NODE_ADDR, 32'h1);
      chk(BIT_CYCLES, CLK_HZ / BAUD_9600);
      rd_chk(OFS_CONFIG, 33'h0_0000_0501);
      rd_chk(8'h20, 33'h1_0000_0000);
      for (i = 0; i < 6; i++) begin
         wr(OFS_CONFIG, 32'h7e | (i << 8));
         repeat (2) @(negedge MCLK);
         chk(BIT_CYCLES, CLK_HZ / (BAUD_300 << i));
      end
      wr(OFS_CONFIG, 32'h0000_367f);
      rd_chk(OFS_CONFIG, 33'h0_0000_057e);
      for (i = 0; i < 4; i++) u_mst.send_par(2'(i));
      repeat (2) @(posedge MCLK);
      chk({NODE_ADDR, BIT_CYCLES}, {7'h7e, 17'(CLK_HZ / BAUD_9600)});
      $display("settings done %0d", err_total);
      for (j = 0; j < 2; j++) begin
         wr(OFS_REF_LIMITS, j ? 32'h1100_0100 : 32'h4000_0000);
         for (i = 0; i < 6; i++) begin
            u_mst.send_ref(refs[i]);
            repeat (3) @(posedge MCLK);
            chk(REF_SPEED, exp_speed(j ? 16'h0100 : 16'h0, j ? 16'h1100 : 16'h4000, refs[i]));
            chk(REF_REVERSE, refs[i][15]);
         end
      end
      $display("reference done %0d", err_total);
      wr(OFS_FREQ_LIMITS, 32'h0032_0000);
      for (i = 0; i < 8; i++) begin
         pins <= spin[i];
         OUT_FREQ <= sfrq[i];
         repeat (4) @(posedge MCLK);
         reply();
         chk(st, sexp[i]);
         chk(fc, (sfrq[i] * 32'h4000) / 32'h32);
      end
      $display("status done %0d", err_total);
      pins <= 6'h00;
      OUT_FREQ <= 16'h0;
      wr(OFS_CURRENT, 32'h0001_0100);
      for (j = 0; j < 2; j++) begin
         OUT_CURRENT <= 16'h0200;
         reply();
         chk(st, 32'h4000);
         chk(TRIP, 32'h0);
         repeat (20) @(posedge MCLK);
         rd_chk(OFS_STATUS, 33'h0_0001_4000);
         OUT_CURRENT <= 16'h0;
         if (j == 0) wr(OFS_STATUS, 32'h0001_0000);
         else trip_rst <= 1'b1;
         repeat (4) @(posedge MCLK);
         trip_rst <= 1'b0;
         chk(TRIP, 32'h0);
      end
      $display("trip done %0d", err_total);
      print_verdict();
   end
endmodule : tb_top
